/* rtl/rmd_pkg.sv */
// constants for the remote i/o station map and switch decoder
package rmd_pkg;

  localparam int          NUM_SLOTS          = 8;
  localparam int          NUM_STATIONS       = 8;
  localparam int          SW_W               = 3;
  localparam int          WORD_W             = 32;

  // station masks, bit k is station k+1
  localparam logic [7:0]  OPP_STN_MASK       = 8'h38;
  localparam logic [7:0]  PIO_SMALL_MASK     = 8'hc3;
  localparam logic [7:0]  PIO_LARGE_MASK     = 8'hc7;

  // rotary switch setting ranges
  localparam logic [3:0]  DIR_SET_MAX        = 4'h7;
  localparam logic [3:0]  PIO_SMALL_SET_MIN  = 4'h2;
  localparam logic [3:0]  PIO_LARGE_SET_MIN  = 4'h3;
  localparam logic [3:0]  PIO_SET_MAX        = 4'h5;

  // device number map
  localparam logic [11:0] STATION_SPAN       = 12'h020;
  localparam logic [11:0] STATION_LAST_OFS   = 12'h01f;
  localparam logic [11:0] PANEL_CH_BASE      = 12'h200;
  localparam logic [11:0] DIRECT_DEV_MAX     = 12'h0ff;
  localparam logic [2:0]  PANEL_CH_LAST_STN  = 3'h5;

  // station 4 word layout
  localparam int          FEED_LSB           = 0;
  localparam int          FEED_GRAY_W        = 5;
  localparam int          FEED_PAR_BIT       = 5;
  localparam int          SPDL_LSB           = 6;
  localparam int          SPDL_W             = 5;
  localparam int          PROTECT_BIT        = 12;
  localparam logic [4:0]  FEED_MAX           = 5'h14;
  localparam logic [4:0]  FEED_RST           = 5'h00;
  localparam logic [2:0]  SPDL_RST           = 3'h0;
  // spindle codes, position 7 down to 0, bit 0 of each is the first input
  localparam logic [39:0] SPDL_CODES         = {5'h14, 5'h05, 5'h17, 5'h06, 5'h12, 5'h03, 5'h10, 5'h00};

  // main panel keys and lamps
  localparam int          KEY_COUNT          = 55;
  localparam int          STN6_KEY_W         = 23;

endpackage

/* rtl/rmd_switch_decoder.sv */
// override switch and protection key decoder for the secondary panel station
`timescale 1ns/100ps
`default_nettype none

module rmd_switch_decoder
  import rmd_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              enable_in,
  input  wire logic [WORD_W-1:0] stn4_word_in,
  output logic      [4:0]        feed_ovr_out,
  output logic                   feed_bad_out,
  output logic      [2:0]        spdl_ovr_out,
  output logic                   spdl_bad_out,
  output logic                   protect_key_out
);

  logic [4:0] feed_reg,    feed_next;
  logic       feed_bad_reg, feed_bad_next;
  logic [2:0] spdl_reg,    spdl_next;
  logic       spdl_bad_reg, spdl_bad_next;
  logic       prot_reg,    prot_next;
  logic [4:0] gray;
  logic [4:0] bin;
  logic [4:0] spdl_code;
  logic       spdl_hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    gray      = stn4_word_in[FEED_LSB +: FEED_GRAY_W];
    spdl_code = stn4_word_in[SPDL_LSB +: SPDL_W];
    bin[4]    = gray[4];
    for (int i = 3; i >= 0; i--) begin
      bin[i] = bin[i+1] ^ gray[i];
    end
    spdl_hit  = 1'b0;
    spdl_next = spdl_reg;
    for (int p = 0; p < 8; p++) begin
      if (spdl_code == SPDL_CODES[p*5 +: 5]) begin
        spdl_hit  = 1'b1;
        spdl_next = p[2:0];
      end
    end
    feed_next     = feed_reg;
    feed_bad_next = feed_bad_reg;
    spdl_bad_next = spdl_bad_reg;
    prot_next     = prot_reg;
    if (enable_in) begin
      if (bin <= FEED_MAX && bin[0] == stn4_word_in[FEED_PAR_BIT]) begin
        feed_next     = bin;
        feed_bad_next = 1'b0;
      end else begin
        feed_bad_next = 1'b1;
      end
      spdl_bad_next = !spdl_hit;
      prot_next     = stn4_word_in[PROTECT_BIT];
    end else begin
      spdl_next = spdl_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      feed_reg     <= FEED_RST;
      feed_bad_reg <= 1'b0;
      spdl_reg     <= SPDL_RST;
      spdl_bad_reg <= 1'b0;
      prot_reg     <= 1'b0;
    end else begin
      feed_reg     <= feed_next;
      feed_bad_reg <= feed_bad_next;
      spdl_reg     <= spdl_next;
      spdl_bad_reg <= spdl_bad_next;
      prot_reg     <= prot_next;
    end
  end

  assign feed_ovr_out    = feed_reg;
  assign feed_bad_out    = feed_bad_reg;
  assign spdl_ovr_out    = spdl_reg;
  assign spdl_bad_out    = spdl_bad_reg;
  assign protect_key_out = prot_reg;

endmodule // rmd_switch_decoder

`default_nettype wire

/* rtl/rmd_station_map.sv */
// station allocator, device number map and operator panel decoder for the remote i/o link
`timescale 1ns/100ps
`default_nettype none

// Operation
// - a unit with one rotary switch takes one station and a two-switch unit takes two consecutive stations.
// - behind the panel i/o unit, that unit claims stations 1, 2, 7, 8 or 1, 2, 3, 7, 8, with 7 and 8 for handles.
// - small panel units allow stations 3 to 6 with settings 2 to 5, larger ones stations 4 to 6 with settings 3 to 5.
// - units overlapping the operator panel's stations on its channel are invalidated together with the operator panel, while the rest keep working.
// - each station maps to 32 inputs and 32 outputs at (n-1)*20 hex, plus 200 hex on the panel channel.
// - the operator panel uses stations 4 to 6, station 4 for its switches with 16 points vacant.
// - feed override is a 21-position reflected gray code on five bits plus the low binary bit.
// - spindle override is eight positions on five bits with one bit unused.
// - the protection key is one bit and the next three bits are spare.
// - the main panel gives 55 key bits and takes 55 lamp bits in stations 5 and 6.
// - the emergency stop is wired directly and never taken from a link word.
// - a direct channel spans device numbers 000 to 0ff only.
module rmd_station_map
  import rmd_pkg::*;
(
  input  wire logic                      clock_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [NUM_SLOTS-1:0]      dir_unit_en_in,
  input  wire logic [NUM_SLOTS-1:0]      dir_unit_dual_in,
  input  wire logic [NUM_SLOTS*SW_W-1:0] dir_unit_sw_in,
  input  wire logic [NUM_SLOTS-1:0]      pnl_unit_en_in,
  input  wire logic [NUM_SLOTS-1:0]      pnl_unit_dual_in,
  input  wire logic [NUM_SLOTS*SW_W-1:0] pnl_unit_sw_in,
  input  wire logic                      pio_present_in,
  input  wire logic                      pio_large_in,
  input  wire logic                      opp_present_in,
  input  wire logic                      opp_on_panel_ch_in,
  input  wire logic [WORD_W-1:0]         stn4_word_in,
  input  wire logic [WORD_W-1:0]         stn5_word_in,
  input  wire logic [WORD_W-1:0]         stn6_word_in,
  input  wire logic                      estop_in,
  input  wire logic [KEY_COUNT-1:0]      lamp_in,
  input  wire logic [2:0]                map_station_in,
  input  wire logic                      map_panel_ch_in,
  output logic      [NUM_SLOTS-1:0]      dir_unit_ok_out,
  output logic      [NUM_SLOTS-1:0]      pnl_unit_ok_out,
  output logic                           opp_ok_out,
  output logic      [NUM_STATIONS-1:0]   dir_stn_fault_out,
  output logic      [NUM_STATIONS-1:0]   pnl_stn_fault_out,
  output logic                           cfg_fault_out,
  output logic      [11:0]               map_first_out,
  output logic      [11:0]               map_last_out,
  output logic                           map_valid_out,
  output logic      [KEY_COUNT-1:0]      keys_out,
  output logic      [WORD_W-1:0]         stn5_lamp_out,
  output logic      [WORD_W-1:0]         stn6_lamp_out,
  output logic      [4:0]                feed_ovr_out,
  output logic                           feed_bad_out,
  output logic      [2:0]                spdl_ovr_out,
  output logic                           spdl_bad_out,
  output logic                           protect_key_out,
  output logic                           estop_out
);

  localparam int CFG_W  = 2 * NUM_SLOTS * (2 + SW_W) + 4;
  localparam int SYNC_W = CFG_W + 3 * WORD_W + 1;

  ////////////////////////////////////////////////////////////////////////////
  // two flip-flop synchronisers for everything arriving from the pins except lamp_in, map_station_in and map_panel_ch_in

  logic [SYNC_W-1:0] sync_a_reg, sync_b_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      sync_a_reg <= {dir_unit_en_in, dir_unit_dual_in, dir_unit_sw_in,
                     pnl_unit_en_in, pnl_unit_dual_in, pnl_unit_sw_in,
                     pio_present_in, pio_large_in, opp_present_in, opp_on_panel_ch_in,
                     stn4_word_in, stn5_word_in, stn6_word_in, estop_in};
      sync_b_reg <= sync_a_reg;
    end
  end

  logic [NUM_SLOTS-1:0]      s_dir_en, s_dir_dual, s_pnl_en, s_pnl_dual;
  logic [NUM_SLOTS*SW_W-1:0] s_dir_sw, s_pnl_sw;
  logic                      s_pio, s_pio_large, s_opp, s_opp_pnl, s_estop;
  logic [WORD_W-1:0]         s_stn4, s_stn5, s_stn6;

  assign {s_dir_en, s_dir_dual, s_dir_sw, s_pnl_en, s_pnl_dual, s_pnl_sw,
          s_pio, s_pio_large, s_opp, s_opp_pnl, s_stn4, s_stn5, s_stn6, s_estop} = sync_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // per-slot station claims and setting range checks

  logic [NUM_STATIONS-1:0] dir_mask [NUM_SLOTS];
  logic [NUM_STATIONS-1:0] pnl_mask [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]    dir_range_ok, pnl_range_ok;
  logic [3:0]              pnl_set_min;

  assign pnl_set_min = s_pio_large ? PIO_LARGE_SET_MIN : PIO_SMALL_SET_MIN;

  generate
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
      logic [3:0] dir_first, dir_last, pnl_first, pnl_last;
      assign dir_first       = {1'b0, s_dir_sw[i*SW_W +: SW_W]};
      assign dir_last        = dir_first + {3'h0, s_dir_dual[i]};
      assign pnl_first       = {1'b0, s_pnl_sw[i*SW_W +: SW_W]};
      assign pnl_last        = pnl_first + {3'h0, s_pnl_dual[i]};
      assign dir_mask[i]     = s_dir_en[i] ?
                               ((8'h01 << dir_first[2:0]) | (s_dir_dual[i] ? (8'h02 << dir_first[2:0]) : 8'h00)) : 8'h00;
      assign pnl_mask[i]     = s_pnl_en[i] ?
                               ((8'h01 << pnl_first[2:0]) | (s_pnl_dual[i] ? (8'h02 << pnl_first[2:0]) : 8'h00)) : 8'h00;
      assign dir_range_ok[i] = dir_last <= DIR_SET_MAX;
      assign pnl_range_ok[i] = s_pio && pnl_first >= pnl_set_min && pnl_last <= PIO_SET_MAX;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // overlap detection and unit validity

  logic [NUM_SLOTS-1:0]    dir_ok_reg, dir_ok_next, pnl_ok_reg, pnl_ok_next;
  logic                    opp_ok_reg, opp_ok_next, fault_reg, fault_next;
  logic [NUM_STATIONS-1:0] dir_fault_reg, dir_fault_next, pnl_fault_reg, pnl_fault_next;
  logic [NUM_STATIONS-1:0] dir_once, dir_twice, pnl_once, pnl_twice, pio_mask, opp_dir, opp_pnl;

  always_comb begin
    pio_mask  = s_pio ? (s_pio_large ? PIO_LARGE_MASK : PIO_SMALL_MASK) : 8'h00;
    opp_dir   = (s_opp && !s_opp_pnl) ? OPP_STN_MASK : 8'h00;
    opp_pnl   = (s_opp && s_opp_pnl) ? OPP_STN_MASK : 8'h00;
    dir_once  = opp_dir;
    dir_twice = 8'h00;
    pnl_once  = pio_mask | opp_pnl;
    pnl_twice = pio_mask & opp_pnl;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      dir_twice = dir_twice | (dir_once & dir_mask[i]);
      dir_once  = dir_once | dir_mask[i];
      pnl_twice = pnl_twice | (pnl_once & pnl_mask[i]);
      pnl_once  = pnl_once | pnl_mask[i];
    end
    for (int i = 0; i < NUM_SLOTS; i++) begin
      dir_ok_next[i] = s_dir_en[i] && dir_range_ok[i] && !(|(dir_mask[i] & dir_twice));
      pnl_ok_next[i] = s_pnl_en[i] && pnl_range_ok[i] && !(|(pnl_mask[i] & pnl_twice));
    end
    opp_ok_next    = s_opp && !(|(OPP_STN_MASK & (s_opp_pnl ? pnl_twice : dir_twice)));
    dir_fault_next = dir_twice;
    pnl_fault_next = pnl_twice;
    fault_next     = |{dir_twice, pnl_twice};
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dir_ok_reg    <= '0;
      pnl_ok_reg    <= '0;
      opp_ok_reg    <= 1'b0;
      dir_fault_reg <= '0;
      pnl_fault_reg <= '0;
      fault_reg     <= 1'b0;
    end else begin
      dir_ok_reg    <= dir_ok_next;
      pnl_ok_reg    <= pnl_ok_next;
      opp_ok_reg    <= opp_ok_next;
      dir_fault_reg <= dir_fault_next;
      pnl_fault_reg <= pnl_fault_next;
      fault_reg     <= fault_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // station to device number map

  logic [11:0] first_reg, first_next, last_reg, last_next;
  logic        mvalid_reg, mvalid_next;

  always_comb begin
    first_next  = 12'(map_station_in * STATION_SPAN) + (map_panel_ch_in ? PANEL_CH_BASE : 12'h000);
    last_next   = first_next + STATION_LAST_OFS;
    mvalid_next = map_panel_ch_in ? (map_station_in <= PANEL_CH_LAST_STN)
                                  : (last_next <= DIRECT_DEV_MAX);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      first_reg  <= 12'h000;
      last_reg   <= 12'h000;
      mvalid_reg <= 1'b0;
    end else begin
      first_reg  <= first_next;
      last_reg   <= last_next;
      mvalid_reg <= mvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main panel keys and lamps, direct emergency stop

  logic [KEY_COUNT-1:0] keys_reg, keys_next;
  logic [WORD_W-1:0]    lamp5_reg, lamp5_next, lamp6_reg, lamp6_next;
  logic                 estop_reg, estop_next;

  always_comb begin
    keys_next  = '0;
    lamp5_next = '0;
    lamp6_next = '0;
    if (opp_ok_reg) begin
      keys_next  = {s_stn6[STN6_KEY_W-1:0], s_stn5};
      lamp5_next = lamp_in[WORD_W-1:0];
      lamp6_next = {{(WORD_W-STN6_KEY_W){1'b0}}, lamp_in[KEY_COUNT-1:WORD_W]};
    end
    estop_next = s_estop;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      keys_reg  <= '0;
      lamp5_reg <= '0;
      lamp6_reg <= '0;
      estop_reg <= 1'b0;
    end else begin
      keys_reg  <= keys_next;
      lamp5_reg <= lamp5_next;
      lamp6_reg <= lamp6_next;
      estop_reg <= estop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary panel switches, station 4 upper half vacant

  rmd_switch_decoder u_switch_decoder (
    .clock_in        (clock_in),
    .sys_rst_in      (sys_rst_in),
    .enable_in       (opp_ok_reg),
    .stn4_word_in    (s_stn4),
    .feed_ovr_out    (feed_ovr_out),
    .feed_bad_out    (feed_bad_out),
    .spdl_ovr_out    (spdl_ovr_out),
    .spdl_bad_out    (spdl_bad_out),
    .protect_key_out (protect_key_out)
  );

  assign dir_unit_ok_out   = dir_ok_reg;
  assign pnl_unit_ok_out   = pnl_ok_reg;
  assign opp_ok_out        = opp_ok_reg;
  assign dir_stn_fault_out = dir_fault_reg;
  assign pnl_stn_fault_out = pnl_fault_reg;
  assign cfg_fault_out     = fault_reg;
  assign map_first_out     = first_reg;
  assign map_last_out      = last_reg;
  assign map_valid_out     = mvalid_reg;
  assign keys_out          = keys_reg;
  assign stn5_lamp_out     = lamp5_reg;
  assign stn6_lamp_out     = lamp6_reg;
  assign estop_out         = estop_reg;

endmodule // rmd_station_map

`default_nettype wire

/* bench/rmd_station_map_monitor.sv */
// concurrent checks on the ports of the station map and switch decoder
`timescale 1ns/100ps
`default_nettype none

module rmd_station_map_monitor
  import rmd_pkg::*;
(
  input wire logic                    clock_in,
  input wire logic                    sys_rst_in,
  input wire logic [2:0]              map_station_in,
  input wire logic                    map_panel_ch_in,
  input wire logic [11:0]             map_first_out,
  input wire logic [11:0]             map_last_out,
  input wire logic                    map_valid_out,
  input wire logic [NUM_STATIONS-1:0] dir_stn_fault_out,
  input wire logic [NUM_STATIONS-1:0] pnl_stn_fault_out,
  input wire logic                    cfg_fault_out,
  input wire logic                    opp_ok_out,
  input wire logic [KEY_COUNT-1:0]    lamp_in,
  input wire logic [WORD_W-1:0]       stn5_lamp_out,
  input wire logic [WORD_W-1:0]       stn6_lamp_out,
  input wire logic [4:0]              feed_ovr_out,
  input wire logic                    feed_bad_out,
  input wire logic [2:0]              spdl_ovr_out,
  input wire logic                    spdl_bad_out,
  input wire logic                    estop_in,
  input wire logic                    estop_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////////////
  chk_map_first: assert property (
    !$past(sys_rst_in) |-> map_first_out == {2'b00, $past(map_panel_ch_in), 1'b0, $past(map_station_in), 5'h00})
    else $error("station first device number wrong");
  chk_map_last: assert property (
    map_valid_out |-> map_last_out == map_first_out + 12'h01f) else $error("station last device number wrong");
  chk_map_valid: assert property (
    !$past(sys_rst_in) |-> map_valid_out == !($past(map_panel_ch_in) && $past(map_station_in) > 3'h5))
    else $error("station existence flag wrong");
  chk_fault_sum: assert property (
    cfg_fault_out == (|{dir_stn_fault_out, pnl_stn_fault_out})) else $error("fault summary wrong");
  chk_lamp_copy: assert property (
    opp_ok_out && $past(opp_ok_out) |-> stn5_lamp_out == $past(lamp_in[31:0])
      && stn6_lamp_out == {9'h000, $past(lamp_in[54:32])}) else $error("lamp words wrong");
  chk_feed_hold: assert property (
    feed_bad_out |-> $stable(feed_ovr_out)) else $error("feed override not held");
  chk_spdl_hold: assert property (
    spdl_bad_out |-> $stable(spdl_ovr_out)) else $error("spindle override not held");
  chk_estop_path: assert property (
    $rose(estop_out) |-> $past(estop_in, 3)) else $error("stop output without stop input");
  //////////////////////////////////////////////////////////////////////////////
  cover property (cfg_fault_out);
  cover property (feed_bad_out && spdl_bad_out);
  cover property (map_valid_out && map_first_out[9]);
endmodule // rmd_station_map_monitor

bind rmd_station_map rmd_station_map_monitor i_rmd_station_map_monitor (
  .clock_in, .sys_rst_in, .map_station_in, .map_panel_ch_in, .map_first_out, .map_last_out, .map_valid_out,
  .dir_stn_fault_out, .pnl_stn_fault_out, .cfg_fault_out, .opp_ok_out, .lamp_in, .stn5_lamp_out,
  .stn6_lamp_out, .feed_ovr_out, .feed_bad_out, .spdl_ovr_out, .spdl_bad_out, .estop_in, .estop_out);

`default_nettype wire

/* bench/rmd_panel_model.sv */
// operator panel model producing the station 4, 5 and 6 input words
`timescale 1ns/100ps
`default_nettype none

module rmd_panel_model
  import rmd_pkg::*;
(
  input  wire logic                 clock_in,
  input  wire logic [4:0]           feed_pos_in,
  input  wire logic [2:0]           spdl_pos_in,
  input  wire logic                 protect_in,
  input  wire logic                 feed_err_in,
  input  wire logic                 spdl_err_in,
  input  wire logic [KEY_COUNT-1:0] keys_in,
  output logic      [WORD_W-1:0]    stn4_word_out,
  output logic      [WORD_W-1:0]    stn5_word_out,
  output logic      [WORD_W-1:0]    stn6_word_out
);
  localparam logic [4:0] SPDL_TAB [8] = '{5'h00, 5'h10, 5'h03, 5'h12, 5'h06, 5'h17, 5'h05, 5'h14};
  logic [15:0] churn_reg = 16'h5a3c;
  //////////////////////////////////////////////////////////////////////////////
  // vacant and spare points change every cycle
  always @(posedge clock_in) churn_reg <= churn_reg + 16'h1357;
  always_comb begin
    stn4_word_out = {churn_reg, churn_reg[2:0], protect_in, churn_reg[3],
                     spdl_err_in ? 5'h1f : SPDL_TAB[spdl_pos_in],
                     feed_pos_in[0] ^ feed_err_in, feed_pos_in ^ (feed_pos_in >> 1)};
    stn5_word_out = keys_in[31:0];
    stn6_word_out = {churn_reg[8:0], keys_in[54:32]};
  end
endmodule // rmd_panel_model

`default_nettype wire

/* bench/rmd_station_map_tb.sv */
// self-checking testbench for the station map and switch decoder
`timescale 1ns/100ps
`default_nettype none

module rmd_station_map_tb;
  import rmd_pkg::*;
  logic        clock_in = 1'b0, sys_rst_in = 1'b1;
  logic [7:0]  dir_unit_en_in = '0, dir_unit_dual_in = '0, pnl_unit_en_in = '0, pnl_unit_dual_in = '0;
  logic [23:0] dir_unit_sw_in = '0, pnl_unit_sw_in = '0;
  logic        pio_present_in = 0, pio_large_in = 0, opp_present_in = 0, opp_on_panel_ch_in = 0, estop_in = 0;
  logic [54:0] lamp_in = '0, keys_m = '0, keys_out;
  logic [2:0]  map_station_in = '0, spdl_pos = '0, spdl_ovr_out;
  logic [4:0]  feed_pos = '0, feed_ovr_out;
  logic        map_panel_ch_in = 0, prot = 0, f_err = 0, s_err = 0;
  logic [31:0] stn4_word_in, stn5_word_in, stn6_word_in, stn5_lamp_out, stn6_lamp_out;
  logic [7:0]  dir_unit_ok_out, pnl_unit_ok_out, dir_stn_fault_out, pnl_stn_fault_out;
  logic [11:0] map_first_out, map_last_out;
  logic        opp_ok_out, cfg_fault_out, map_valid_out, feed_bad_out, spdl_bad_out, protect_key_out, estop_out;
  int          failures = 0, n_checks = 0, cycles = 0;

  rmd_station_map i_rmd_station_map (.clock_in, .sys_rst_in, .dir_unit_en_in, .dir_unit_dual_in, .dir_unit_sw_in,
    .pnl_unit_en_in, .pnl_unit_dual_in, .pnl_unit_sw_in, .pio_present_in, .pio_large_in, .opp_present_in,
    .opp_on_panel_ch_in, .stn4_word_in, .stn5_word_in, .stn6_word_in, .estop_in, .lamp_in, .map_station_in,
    .map_panel_ch_in, .dir_unit_ok_out, .pnl_unit_ok_out, .opp_ok_out, .dir_stn_fault_out, .pnl_stn_fault_out,
    .cfg_fault_out, .map_first_out, .map_last_out, .map_valid_out, .keys_out, .stn5_lamp_out, .stn6_lamp_out,
    .feed_ovr_out, .feed_bad_out, .spdl_ovr_out, .spdl_bad_out, .protect_key_out, .estop_out);
  rmd_panel_model i_rmd_panel_model (.clock_in, .feed_pos_in(feed_pos), .spdl_pos_in(spdl_pos), .protect_in(prot),
    .feed_err_in(f_err), .spdl_err_in(s_err), .keys_in(keys_m), .stn4_word_out(stn4_word_in),
    .stn5_word_out(stn5_word_in), .stn6_word_out(stn6_word_in));
  //////////////////////////////////////////////////////////////////////////////
  always #50 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    step(8);
    sys_rst_in = 0;
    check({cfg_fault_out, opp_ok_out, dir_unit_ok_out, feed_ovr_out}, '0);
    for (int c = 0; c < 2; c++) for (int s = 0; s < 8; s++) begin
      map_station_in = s[2:0];
      map_panel_ch_in = c[0];
      step(1);
      check(map_first_out, s * 32 + c * 512);
      check(map_last_out, s * 32 + c * 512 + 31);
      check(map_valid_out, !(c == 1 && s > 5));
    end
    $display("test map done");
    opp_present_in = 1;
    dir_unit_en_in = 8'h0f;
    dir_unit_dual_in = 8'h08;
    dir_unit_sw_in = {9'h000, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
    step(4);
    check({dir_unit_ok_out, opp_ok_out, dir_stn_fault_out}, {8'h03, 1'b0, 8'h08});
    dir_unit_en_in = 8'h0b;
    step(4);
    check({dir_unit_ok_out, opp_ok_out, cfg_fault_out}, {8'h03, 2'b10});
    dir_unit_dual_in = 8'h0a;
    dir_unit_sw_in[5:3] = 3'h2;
    step(4);
    check({dir_unit_ok_out, opp_ok_out, dir_stn_fault_out}, {8'h01, 1'b0, 8'h08});
    $display("test direct done");
    dir_unit_en_in = '0;
    opp_on_panel_ch_in = 1;
    pio_present_in = 1;
    pnl_unit_en_in = 8'h03;
    pnl_unit_sw_in = {18'h00000, 3'h1, 3'h2};
    step(4);
    check({pnl_unit_ok_out, opp_ok_out}, {8'h01, 1'b1});
    pio_large_in = 1;
    pnl_unit_en_in = 8'h01;
    step(4);
    check({pnl_unit_ok_out, opp_ok_out}, {8'h00, 1'b1});
    pnl_unit_sw_in[2:0] = 3'h3;
    step(4);
    check({pnl_unit_ok_out, opp_ok_out, pnl_stn_fault_out}, {8'h00, 1'b0, 8'h08});
    pio_present_in = 0;
    opp_present_in = 0;
    step(4);
    check(pnl_unit_ok_out, 8'h00);
    $display("test panel done");
    pnl_unit_en_in = '0;
    opp_present_in = 1;
    opp_on_panel_ch_in = 0;
    for (int p = 0; p <= 20; p++) begin
      feed_pos = p[4:0];
      spdl_pos = p[2:0];
      prot = p[0];
      step(4);
      check({feed_bad_out, feed_ovr_out}, {1'b0, p[4:0]});
      check({spdl_bad_out, spdl_ovr_out}, {1'b0, p[2:0]});
      check(protect_key_out, p[0]);
    end
    f_err = 1;
    s_err = 1;
    step(4);
    check({feed_bad_out, feed_ovr_out, spdl_bad_out, spdl_ovr_out}, {6'h34, 4'hc});
    f_err = 0;
    s_err = 0;
    $display("test decoder done");
    keys_m = 55'h5a_1234_89ab_cdef;
    lamp_in = 55'h2b_fedc_ba98_7654;
    estop_in = 1;
    step(4);
    check(keys_out, keys_m);
    check({stn6_lamp_out, stn5_lamp_out}, {9'h000, lamp_in});
    check(estop_out, 1'b1);
    opp_present_in = 0;
    step(4);
    feed_pos = 5'h03;
    step(4);
    check({keys_out, stn6_lamp_out, stn5_lamp_out, feed_ovr_out}, {119'h0, 5'h14});
    sys_rst_in = 1;
    step(2);
    sys_rst_in = 0;
    check({keys_out, feed_ovr_out, estop_out, dir_unit_ok_out}, '0);
    step(4);
    check(estop_out, 1'b1);
    $display("test keys done");
    wrap_up();
  end
endmodule // rmd_station_map_tb

`default_nettype wire
